//--- ppc_top.sv
// Downstream port power, overcurrent and charging configuration
//
// Operation
// - Dynamic charge disable low suspends charging everywhere; high resumes configured mode.
// - Shorted-line emulation only in dedicated charging operation; 1A/2A profile follows its setting in any mode unless legacy.
// - Legacy voltage mode drives data lines whenever a legacy port charges, also with power requested and good.
// - Concurrent mode picks 1A or 2A profile per port beside BC 1.2.
// - Legacy mode on a port overrides and ignores its 1A/2A profile.
// - Charging ports force per-port power and overcurrent; no ganging then.
// - External switch bus only on charging ports, pins of ports 1-4.
// - Any non-removable port makes both hubs report compound device.
// - Unless disabled, straps on ports 1-4 override file settings.
// - Shared enable/sense pin choice only on ports 1-4; 5-7 combined.
// - Ganged ports report overcurrent together; all-ganged makes one gang.
// - Split gang: selected ports share a GPIO sense input per hub.
// - Power gang drives every port from one common control.
// - No power controls: power-on time zero, switch control signal set.
// - Power-on to power-good counted in 2 ms units of configured value.
// - USB 2.0 sense filter selects 50, 1000, 200 or 400 ns.
// - USB 3.0 sense filter selects 750, 10000, 1250 or 1500 ns.
// - Per-port swap of USB 2.0 data lines, port 0 upstream.
// - Per-port disable turns port off in both hubs.
// - Report 16-bit vendor id and separate 16-bit product ids.
// - Manufacturer, product and serial strings hold at most 30 chars.
// - Hardware reset ends everything and restores defaults.
`timescale 1ns/1ps
`default_nettype none
module ppc_top
	import ppc_pkg::*;
#(
	parameter int PON_CYC = PON_UNIT_CYC
)
(
	input  wire logic                 mclk_i,
	input  wire logic                 resetn_i,
	input  wire ppc_port_cfg_t        port_cfg_i,
	input  wire ppc_glb_cfg_t         glb_cfg_i,
	input  wire ppc_strap_t           strap_i,
	input  wire logic                 dynamic_charge_disable_n_i,
	input  wire logic [NPORT-1:0]     port_power_request_i,
	input  wire logic [NPORT-1:0]     oc_sense_n_i,
	input  wire logic                 oc_gang_gpio_n_i,
	output var  logic [NPORT-1:0]     port_power_control_o,
	output var  logic [NPORT-1:0]     port_power_control_oe_o,
	output var  ppc_chg_t [NPORT-1:0] chg_mode_o,
	output var  logic [NPORT-1:0]     prof_2a_o,
	output var  logic [NPORT-1:0]     short_emul_o,
	output var  logic [NPORT-1:0]     legacy_drive_o,
	output var  logic [NPORT-1:0]     oc2_o,
	output var  logic [NSS-1:0]       oc3_o,
	output var  logic [NPORT-1:0]     port_off_o,
	output var  logic [NPORT:0]       dpdm_swap_o,
	output var  logic [NSTRAP-1:0]    sm_sel_o,
	output var  logic                 compound_o,
	output var  logic                 power_switch_control_o,
	output var  logic [NPORT-1:0]     power_good_o,
	output var  logic [15:0]          vid_o,
	output var  logic [15:0]          pid2_o,
	output var  logic [15:0]          pid3_o,
	output var  logic [STR_LEN_W-1:0] mfg_len_o,
	output var  logic [STR_LEN_W-1:0] prod_len_o,
	output var  logic [STR_LEN_W-1:0] ser_len_o,
	output var  logic                 cfg_err_o
);
	// ------------------------------------------------------------------
	// State of the block
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [1:0]             dyn_sync;
		logic [NPORT-1:0]       oc_s1;
		logic [NPORT-1:0]       oc_s2;
		logic [1:0]             gpio_sync;
		logic                   strap_done;
		ppc_strap_t             strap;
		logic [NPORT-1:0]       pctl;
		logic [NPORT-1:0]       pctl_oe;
		ppc_chg_t [NPORT-1:0]   chg;
		logic [NPORT-1:0]       p2a;
		logic [NPORT-1:0]       shrt;
		logic [NPORT-1:0]       leg;
		logic [NPORT-1:0]       oc2;
		logic [NSS-1:0]         oc3;
		logic [NPORT-1:0]       off;
		logic [NPORT:0]         swap;
		logic [NSTRAP-1:0]      smsel;
		logic                   comp;
		logic                   pswc;
		logic [NPORT-1:0]       pgood;
		logic [15:0]            vid;
		logic [15:0]            pid2;
		logic [15:0]            pid3;
		logic [STR_LEN_W-1:0]   mlen;
		logic [STR_LEN_W-1:0]   plen;
		logic [STR_LEN_W-1:0]   slen;
		logic                   err;
	} ppc_top_st_t;

	ppc_top_st_t st_q;
	ppc_top_st_t st_d;

	// Effective per-port settings after straps
	logic [NPORT-1:0]       eff_chg;
	logic [NPORT-1:0]       eff_dis;
	logic [NPORT-1:0]       eff_nrem;
	logic [NPORT-1:0]       combined;
	logic [NPORT-1:0]       flt2;
	logic [NPORT-1:0]       flt3;
	logic                   gang_flt2;
	logic                   gang_flt3;
	logic [NPORT-1:0]       pgood_w;
	logic [NPORT-1:0]       pwr_req;
	logic [OCW-1:0]         lim2;
	logic [OCW-1:0]         lim3;
	logic [PON_FIELD_W-1:0] pon_units;
	logic                   any_chg;
	logic                   gang_pwr;
	logic                   gang_all;
	logic                   gang_split;
	logic [NPORT-1:0]       oc_live;

	// ------------------------------------------------------------------
	// Strap override and gang qualification
	// ------------------------------------------------------------------
	always_comb
	begin
		eff_chg  = port_cfg_i.chg_en;
		eff_dis  = port_cfg_i.disable_p;
		eff_nrem = port_cfg_i.nonrem;
		if (!glb_cfg_i.strap_dis)
		begin
			eff_chg[NSTRAP-1:0]  = st_q.strap.chg_en;
			eff_dis[NSTRAP-1:0]  = st_q.strap.disable_p;
			eff_nrem[NSTRAP-1:0] = st_q.strap.nonrem;
		end
		any_chg    = |eff_chg;
		gang_pwr   = glb_cfg_i.pwr_gang && !any_chg;
		gang_all   = glb_cfg_i.oc_mode == PPC_OC_ALL && !any_chg;
		gang_split = glb_cfg_i.oc_mode == PPC_OC_SPLIT && !any_chg;
		// Ports 5-7 have one pin only: always combined
		combined = {{(NPORT-NSTRAP){1'b1}}, port_cfg_i.combined};
		oc_live = st_q.oc_s2 & ~(combined & st_q.pctl_oe);
		pon_units = glb_cfg_i.no_pwr_ctl ? '0 : glb_cfg_i.pon_time;
		pwr_req = port_power_request_i & ~eff_dis;
		unique case (glb_cfg_i.oc2_sel)
			2'h0: lim2 = OC2_C0;
			2'h1: lim2 = OC2_C1;
			2'h2: lim2 = OC2_C2;
			2'h3: lim2 = OC2_C3;
		endcase
		unique case (glb_cfg_i.oc3_sel)
			2'h0: lim3 = OC3_C0;
			2'h1: lim3 = OC3_C1;
			2'h2: lim3 = OC3_C2;
			2'h3: lim3 = OC3_C3;
		endcase
	end

	// ------------------------------------------------------------------
	// Per-port filters and power-on timers
	// ------------------------------------------------------------------
	for (genvar i = 0; i < NPORT; i++)
	begin : g_port
		ppc_oc_filter u_f2 (
			.mclk_i   (mclk_i),
			.resetn_i (resetn_i),
			.sense_i  (oc_live[i]),
			.limit_i  (lim2),
			.oc_o     (flt2[i])
		);
		ppc_oc_filter u_f3 (
			.mclk_i   (mclk_i),
			.resetn_i (resetn_i),
			.sense_i  (oc_live[i]),
			.limit_i  (lim3),
			.oc_o     (flt3[i])
		);
		ppc_pon_timer #(.UNIT_CYC(PON_CYC)) u_pon (
			.mclk_i   (mclk_i),
			.resetn_i (resetn_i),
			.start_i  (gang_pwr ? |pwr_req : pwr_req[i]),
			.units_i  (pon_units),
			.good_o   (pgood_w[i])
		);
	end

	// Filters on the shared gang input for split mode
	ppc_oc_filter u_gf2 (
		.mclk_i   (mclk_i),
		.resetn_i (resetn_i),
		.sense_i  (st_q.gpio_sync[1]),
		.limit_i  (lim2),
		.oc_o     (gang_flt2)
	);
	ppc_oc_filter u_gf3 (
		.mclk_i   (mclk_i),
		.resetn_i (resetn_i),
		.sense_i  (st_q.gpio_sync[1]),
		.limit_i  (lim3),
		.oc_o     (gang_flt3)
	);

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb
	begin
		st_d = st_q;
		// Synchronisers for pins
		st_d.dyn_sync  = {st_q.dyn_sync[0], dynamic_charge_disable_n_i};
		st_d.oc_s1     = ~oc_sense_n_i;
		st_d.oc_s2     = st_q.oc_s1;
		st_d.gpio_sync = {st_q.gpio_sync[0], ~oc_gang_gpio_n_i};
		// Straps caught once, the first clock after reset release
		if (!st_q.strap_done)
		begin
			st_d.strap      = strap_i;
			st_d.strap_done = 1'b1;
		end
		for (int i = 0; i < NPORT; i++)
		begin
			// Charging mode per port
			if (!eff_chg[i] || eff_dis[i] || !st_q.dyn_sync[1])
				st_d.chg[i] = PPC_CHG_OFF;
			else if (port_cfg_i.legacy[i])
				st_d.chg[i] = PPC_CHG_LEG;
			else if (st_q.pgood[i] && port_power_request_i[i])
				st_d.chg[i] = PPC_CHG_CDP;
			else
				st_d.chg[i] = PPC_CHG_DCP;
			st_d.p2a[i]  = port_cfg_i.prof_2a[i] && !port_cfg_i.legacy[i];
			st_d.shrt[i] = st_d.chg[i] == PPC_CHG_DCP;
			st_d.leg[i]  = st_d.chg[i] == PPC_CHG_LEG;
			// USB 2.0 overcurrent with gang merging
			if (gang_all)
				st_d.oc2[i] = |flt2;
			else if (gang_split && port_cfg_i.split_sel[i])
				st_d.oc2[i] = glb_cfg_i.split_gang2 ? gang_flt2 : flt2[i];
			else
				st_d.oc2[i] = flt2[i];
			// Power control: drive enable; if combined, release to sense once enabled and power good
			st_d.pctl[i] = gang_pwr ? |pwr_req : pwr_req[i];
			st_d.pctl_oe[i] = !combined[i] || !st_d.pctl[i] ||
				!st_q.pgood[i];
			st_d.off[i] = eff_dis[i];
		end
		for (int i = 0; i < NSS; i++)
		begin
			if (gang_all)
				st_d.oc3[i] = |flt3[NSS-1:0];
			else if (gang_split && port_cfg_i.split_sel[i])
				st_d.oc3[i] = glb_cfg_i.split_gang3 ? gang_flt3 : flt3[i];
			else
				st_d.oc3[i] = flt3[i];
		end
		st_d.pgood = pgood_w;
		st_d.smsel = port_cfg_i.sm_sel & eff_chg[NSTRAP-1:0];
		st_d.swap  = port_cfg_i.swap;
		st_d.comp  = |eff_nrem;
		st_d.pswc  = glb_cfg_i.no_pwr_ctl;
		st_d.vid   = glb_cfg_i.vid;
		st_d.pid2  = glb_cfg_i.pid2;
		st_d.pid3  = glb_cfg_i.pid3;
		// Lengths clamp to the string limit
		st_d.mlen = glb_cfg_i.mfg_len > STR_LEN_W'(STR_MAX_CHARS) ?
			STR_LEN_W'(STR_MAX_CHARS) : glb_cfg_i.mfg_len;
		st_d.plen = glb_cfg_i.prod_len > STR_LEN_W'(STR_MAX_CHARS) ?
			STR_LEN_W'(STR_MAX_CHARS) : glb_cfg_i.prod_len;
		st_d.slen = glb_cfg_i.ser_len > STR_LEN_W'(STR_MAX_CHARS) ?
			STR_LEN_W'(STR_MAX_CHARS) : glb_cfg_i.ser_len;
		// Flag ganging asked while charging, or switch bus off charge
		st_d.err = (any_chg && (glb_cfg_i.pwr_gang ||
			glb_cfg_i.oc_mode != PPC_OC_INDIV)) ||
			|(port_cfg_i.sm_sel & ~eff_chg[NSTRAP-1:0]);
	end

	// ------------------------------------------------------------------
	// State register; reset drops everything to defaults
	// ------------------------------------------------------------------
	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			st_q          <= '0;
			st_q.dyn_sync <= 2'h3;
			st_q.chg      <= {NPORT{PPC_CHG_OFF}};
			st_q.vid      <= VID_RST;
			st_q.pid2     <= PID2_RST;
			st_q.pid3     <= PID3_RST;
		end
		else
			st_q <= st_d;
	end

	// Outputs straight from the state register
	assign port_power_control_o    = st_q.pctl;
	assign port_power_control_oe_o = st_q.pctl_oe;
	assign chg_mode_o              = st_q.chg;
	assign prof_2a_o               = st_q.p2a;
	assign short_emul_o            = st_q.shrt;
	assign legacy_drive_o          = st_q.leg;
	assign oc2_o                   = st_q.oc2;
	assign oc3_o                   = st_q.oc3;
	assign port_off_o              = st_q.off;
	assign dpdm_swap_o             = st_q.swap;
	assign sm_sel_o                = st_q.smsel;
	assign compound_o              = st_q.comp;
	assign power_switch_control_o  = st_q.pswc;
	assign power_good_o            = st_q.pgood;
	assign vid_o                   = st_q.vid;
	assign pid2_o                  = st_q.pid2;
	assign pid3_o                  = st_q.pid3;
	assign mfg_len_o               = st_q.mlen;
	assign prod_len_o              = st_q.plen;
	assign ser_len_o               = st_q.slen;
	assign cfg_err_o               = st_q.err;
endmodule
`default_nettype wire

//--- ppc_pkg.sv
// Package for the port power and charging configuration block
package ppc_pkg;

	// ------------------------------------------------------------------
	// Sizes
	// ------------------------------------------------------------------
	localparam int NPORT     = 7;
	localparam int NSTRAP    = 4;
	localparam int NSS       = 4;
	localparam int CLK_MHZ   = 50;
	localparam int CLK_NS    = 20;

	// ------------------------------------------------------------------
	// Overcurrent filter times in ns, and their cycle counts
	// ------------------------------------------------------------------
	localparam int OC2_T0_NS = 50;
	localparam int OC2_T1_NS = 1000;
	localparam int OC2_T2_NS = 200;
	localparam int OC2_T3_NS = 400;
	localparam int OC3_T0_NS = 750;
	localparam int OC3_T1_NS = 10000;
	localparam int OC3_T2_NS = 1250;
	localparam int OC3_T3_NS = 1500;
	localparam int OCW       = 10;
	localparam logic [OCW-1:0] OC2_C0 = OCW'((OC2_T0_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [OCW-1:0] OC2_C1 = OCW'((OC2_T1_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [OCW-1:0] OC2_C2 = OCW'((OC2_T2_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [OCW-1:0] OC2_C3 = OCW'((OC2_T3_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [OCW-1:0] OC3_C0 = OCW'((OC3_T0_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [OCW-1:0] OC3_C1 = OCW'((OC3_T1_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [OCW-1:0] OC3_C2 = OCW'((OC3_T2_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [OCW-1:0] OC3_C3 = OCW'((OC3_T3_NS + CLK_NS - 1) / CLK_NS);

	// ------------------------------------------------------------------
	// Power-on to power-good timing and string limits
	// ------------------------------------------------------------------
	localparam int PON_UNIT_MS   = 2;
	localparam int PON_UNIT_CYC  = PON_UNIT_MS * CLK_MHZ * 1000;
	localparam int PONW          = 17;
	localparam int PON_FIELD_W   = 8;
	localparam int STR_MAX_CHARS = 30;
	localparam int STR_LEN_W     = 6;

	// Reset values
	localparam logic [15:0] VID_RST   = 16'h0000;
	localparam logic [15:0] PID2_RST  = 16'h0000;
	localparam logic [15:0] PID3_RST  = 16'h0000;

	// Charging mode of a port as it is applied
	typedef enum logic [3:0] {
		PPC_CHG_OFF  = 4'h1,
		PPC_CHG_CDP  = 4'h2,
		PPC_CHG_DCP  = 4'h4,
		PPC_CHG_LEG  = 4'h8
	} ppc_chg_t;

	// Gang arrangement of overcurrent sensing
	typedef enum logic [1:0] {
		PPC_OC_INDIV = 2'h0,
		PPC_OC_ALL   = 2'h1,
		PPC_OC_SPLIT = 2'h2
	} ppc_ocmode_t;

	// Per-port configuration
	typedef struct packed {
		logic [NPORT-1:0] chg_en;
		logic [NPORT-1:0] prof_2a;
		logic [NPORT-1:0] legacy;
		logic [NPORT-1:0] disable_p;
		logic [NPORT-1:0] nonrem;
		logic [NSTRAP-1:0] combined;
		logic [NPORT:0]   swap;
		logic [NPORT-1:0] split_sel;
		logic [NSTRAP-1:0] sm_sel;
	} ppc_port_cfg_t;

	// Global configuration
	typedef struct packed {
		ppc_ocmode_t            oc_mode;
		logic                   split_gang2;
		logic                   split_gang3;
		logic                   pwr_gang;
		logic                   no_pwr_ctl;
		logic [PON_FIELD_W-1:0] pon_time;
		logic [1:0]             oc2_sel;
		logic [1:0]             oc3_sel;
		logic                   strap_dis;
		logic [15:0]            vid;
		logic [15:0]            pid2;
		logic [15:0]            pid3;
		logic [STR_LEN_W-1:0]   mfg_len;
		logic [STR_LEN_W-1:0]   prod_len;
		logic [STR_LEN_W-1:0]   ser_len;
	} ppc_glb_cfg_t;

	// Pin straps for ports 1-4
	typedef struct packed {
		logic [NSTRAP-1:0] disable_p;
		logic [NSTRAP-1:0] nonrem;
		logic [NSTRAP-1:0] chg_en;
	} ppc_strap_t;

endpackage

//--- ppc_oc_filter.sv
// Overcurrent sense filter: accepts only long enough assertions
`timescale 1ns/1ps
`default_nettype none
module ppc_oc_filter
	import ppc_pkg::*;
(
	input  wire logic           mclk_i,
	input  wire logic           resetn_i,
	input  wire logic           sense_i,
	input  wire logic [OCW-1:0] limit_i,
	output var  logic           oc_o
);
	typedef struct packed {
		logic [OCW-1:0] cnt;
		logic           oc;
	} ppc_flt_st_t;

	ppc_flt_st_t st_q;
	ppc_flt_st_t st_d;

	// ------------------------------------------------------------------
	// Count a continuous assertion; any gap restarts the count
	// ------------------------------------------------------------------
	always_comb
	begin
		st_d = st_q;
		if (!sense_i)
		begin
			st_d.cnt = '0;
			st_d.oc  = 1'b0;
		end
		else if (st_q.cnt + OCW'(1) >= limit_i)
			st_d.oc = 1'b1;
		else
			st_d.cnt = st_q.cnt + OCW'(1);
	end

	// State register
	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	assign oc_o = st_q.oc;
endmodule
`default_nettype wire

//--- ppc_pon_timer.sv
// Power-on to power-good timer counted in 2 ms units
`timescale 1ns/1ps
`default_nettype none
module ppc_pon_timer
	import ppc_pkg::*;
#(
	parameter int UNIT_CYC = PON_UNIT_CYC
)
(
	input  wire logic                   mclk_i,
	input  wire logic                   resetn_i,
	input  wire logic                   start_i,
	input  wire logic [PON_FIELD_W-1:0] units_i,
	output var  logic                   good_o
);
	typedef struct packed {
		logic [PONW-1:0]        tick;
		logic [PON_FIELD_W-1:0] left;
		logic                   run;
		logic                   good;
	} ppc_pon_st_t;

	ppc_pon_st_t st_q;
	ppc_pon_st_t st_d;

	// ------------------------------------------------------------------
	// Start on rising power request; good after units x 2 ms
	// ------------------------------------------------------------------
	always_comb
	begin
		st_d = st_q;
		if (!start_i)
			st_d = '0;
		else if (!st_q.run && !st_q.good)
		begin
			st_d.left = units_i;
			st_d.tick = '0;
			st_d.run  = (units_i != '0);
			st_d.good = (units_i == '0);
		end
		else if (st_q.run)
		begin
			if (st_q.tick == PONW'(UNIT_CYC - 1))
			begin
				st_d.tick = '0;
				st_d.left = st_q.left - PON_FIELD_W'(1);
				if (st_q.left == PON_FIELD_W'(1))
				begin
					st_d.run  = 1'b0;
					st_d.good = 1'b1;
				end
			end
			else
				st_d.tick = st_q.tick + PONW'(1);
		end
	end

	// State register
	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	assign good_o = st_q.good;
endmodule
`default_nettype wire

//--- ppc_top_props.sv
// Concurrent checks on the ports of the port power and charging block
`timescale 1ns/1ps
`default_nettype none
module ppc_top_props
	import ppc_pkg::*;
#(
	parameter int PON_CYC = PON_UNIT_CYC
)
(
	input  wire logic                 mclk_i,
	input  wire logic                 resetn_i,
	input  wire ppc_port_cfg_t        port_cfg_i,
	input  wire ppc_glb_cfg_t         glb_cfg_i,
	input  wire logic                 dynamic_charge_disable_n_i,
	input  wire logic [NPORT-1:0]     oc_sense_n_i,
	input  wire ppc_chg_t [NPORT-1:0] chg_mode_o,
	input  wire logic [NPORT-1:0]     prof_2a_o,
	input  wire logic [NPORT-1:0]     short_emul_o,
	input  wire logic [NPORT-1:0]     legacy_drive_o,
	input  wire logic [NPORT-1:0]     oc2_o,
	input  wire logic [NPORT-1:0]     port_off_o,
	input  wire logic [NPORT:0]       dpdm_swap_o,
	input  wire logic                 compound_o,
	input  wire logic                 power_switch_control_o,
	input  wire logic [15:0]          vid_o,
	input  wire logic [15:0]          pid2_o,
	input  wire logic [15:0]          pid3_o,
	input  wire logic [STR_LEN_W-1:0] mfg_len_o,
	input  wire logic                 cfg_err_o
);
	// ------------------------------------------------------------
	// Helper logic
	// ------------------------------------------------------------
	logic [1:0]       lv_q;
	logic             ok;
	logic [NPORT-1:0] leg_v, dcp_v, off_v;
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!resetn_i);
	// Edges since reset, so past samples are taken after release
	always_ff @(posedge mclk_i or negedge resetn_i)
		if (!resetn_i)
			lv_q <= 2'h0;
		else if (lv_q != 2'h3)
			lv_q <= lv_q + 2'h1;
	assign ok = (lv_q == 2'h3);
	// Decode the one-hot charging mode of each port
	always_comb
		for (int i = 0; i < NPORT; i++)
		begin
			leg_v[i] = (chg_mode_o[i] == PPC_CHG_LEG);
			dcp_v[i] = (chg_mode_o[i] == PPC_CHG_DCP);
			off_v[i] = (chg_mode_o[i] == PPC_CHG_OFF);
		end
	chk_ids_follow: assert property (ok |-> vid_o == $past(glb_cfg_i.vid) &&
		pid2_o == $past(glb_cfg_i.pid2) && pid3_o == $past(glb_cfg_i.pid3))
		else $error("id outputs differ from configuration");
	chk_str_clamp: assert property (ok |-> mfg_len_o ==
		($past(glb_cfg_i.mfg_len) > 6'd30 ? 6'd30 : $past(glb_cfg_i.mfg_len)))
		else $error("string length not clamped");
	chk_swap_follow: assert property (ok |->
		dpdm_swap_o == $past(port_cfg_i.swap)) else $error("swap mismatch");
	chk_compound_any: assert property (ok && $past(glb_cfg_i.strap_dis) |->
		compound_o == $past(|port_cfg_i.nonrem)) else $error("compound wrong");
	chk_port_off: assert property (ok && $past(glb_cfg_i.strap_dis) |->
		port_off_o == $past(port_cfg_i.disable_p)) else $error("port off wrong");
	chk_legacy_only: assert property ((legacy_drive_o & ~leg_v) == '0 &&
		(legacy_drive_o & prof_2a_o) == '0) else $error("legacy drive wrong");
	chk_short_dcp: assert property ((short_emul_o & ~dcp_v) == '0)
		else $error("emulation outside dedicated mode");
	chk_dyn_disable: assert property (!dynamic_charge_disable_n_i [*4] |->
		off_v == 7'h7F && short_emul_o == '0) else $error("charging not off");
	chk_nopwr_flag: assert property (ok |-> power_switch_control_o ==
		$past(glb_cfg_i.no_pwr_ctl)) else $error("switch control wrong");
	chk_oc_filtered: assert property ($rose(oc2_o[0]) &&
		glb_cfg_i.oc_mode == PPC_OC_INDIV |-> $past(!oc_sense_n_i[0], 4))
		else $error("overcurrent without held sense");
	chk_gang_all: assert property (ok && glb_cfg_i.oc_mode == PPC_OC_ALL &&
		$stable(glb_cfg_i) && glb_cfg_i.strap_dis && port_cfg_i.chg_en == '0
		|=> oc2_o == '0 || oc2_o == 7'h7F) else $error("gang split");
	chk_gang_refused: assert property (ok && $past(glb_cfg_i.strap_dis &&
		glb_cfg_i.pwr_gang && port_cfg_i.chg_en != '0) |-> cfg_err_o)
		else $error("ganging with charging not flagged");
endmodule
bind ppc_top ppc_top_props #(.PON_CYC(PON_CYC)) u_ppc_top_props (
	.mclk_i(mclk_i), .resetn_i(resetn_i), .port_cfg_i(port_cfg_i),
	.glb_cfg_i(glb_cfg_i), .oc_sense_n_i(oc_sense_n_i),
	.dynamic_charge_disable_n_i(dynamic_charge_disable_n_i),
	.chg_mode_o(chg_mode_o), .prof_2a_o(prof_2a_o), .oc2_o(oc2_o),
	.short_emul_o(short_emul_o), .legacy_drive_o(legacy_drive_o),
	.port_off_o(port_off_o), .dpdm_swap_o(dpdm_swap_o), .vid_o(vid_o),
	.compound_o(compound_o), .power_switch_control_o(power_switch_control_o),
	.pid2_o(pid2_o), .pid3_o(pid3_o), .mfg_len_o(mfg_len_o),
	.cfg_err_o(cfg_err_o)
);
`default_nettype wire

//--- ppc_switch_model.sv
// Behavioural model of the downstream port power switches
`timescale 1ns/1ps
`default_nettype none
module ppc_switch_model
	import ppc_pkg::*;
(
	input  wire logic             mclk_i,
	input  wire logic [NPORT-1:0] ctl_i,
	input  wire logic [NPORT-1:0] oe_i,
	input  wire logic [NPORT-1:0] comb_i,
	input  wire logic [NPORT-1:0] fault_i,
	output var  logic [NPORT-1:0] sense_n_o
);
	// ------------------------------------------------------------
	// Switch and flag
	// ------------------------------------------------------------
	logic [NPORT-1:0] en_q = '0;
	logic [NPORT-1:0] flag_n;
	logic [NPORT-1:0] pin;
	// Flag pulls low only while the switch is on and faulted
	assign flag_n = ~(fault_i & en_q);
	// Released control pin rises on its pull-up; the flag wins low
	assign pin = ((oe_i & ctl_i) | ~oe_i) & flag_n;
	// Enable input follows the driven or pulled-up control level
	always @(posedge mclk_i)
		en_q <= (oe_i & ctl_i) | ~oe_i;
	// Combined ports sense the shared pin, the others the flag line
	assign sense_n_o = (comb_i & pin) | (~comb_i & flag_n);
endmodule
`default_nettype wire

//--- ppc_top_test.sv
// Self-checking bench for the port power and charging block
`timescale 1ns/1ps
`default_nettype none
module ppc_top_test
	import ppc_pkg::*;
;
	// ------------------------------------------------------------
	// Stimulus and design
	// ------------------------------------------------------------
	localparam int PCYC = 10;
	logic                 mclk_i   = 1'b0;
	logic                 resetn_i = 1'b0;
	logic                 dcd_n    = 1'b1;
	logic                 gpio_n   = 1'b1;
	ppc_port_cfg_t        pc       = '0;
	ppc_glb_cfg_t         gc       = '0;
	ppc_strap_t           st       = '0;
	logic [NPORT-1:0]     req      = '0;
	logic [NPORT-1:0]     flt      = '0;
	logic [NPORT-1:0]     sense_n, ctl, ctl_oe, p2a, shrt, leg, oc2, off, pg;
	ppc_chg_t [NPORT-1:0] chg;
	logic [NSS-1:0]       oc3, smsel;
	logic [NPORT:0]       swp;
	logic                 cmp, psw, cerr;
	logic [15:0]          vid, pid2, pid3;
	logic [STR_LEN_W-1:0] mlen, plen, slen;
	int                   err_count = 0;
	int                   checks    = 0;
	int                   cyc_count = 0;
	int                   n2[4]     = '{50, 1000, 200, 400};
	int                   n3[4]     = '{750, 10000, 1250, 1500};
	always #10 mclk_i = ~mclk_i;
	ppc_top #(.PON_CYC(PCYC)) u_ppc_top (
		.mclk_i(mclk_i), .resetn_i(resetn_i), .port_cfg_i(pc),
		.glb_cfg_i(gc), .strap_i(st), .dynamic_charge_disable_n_i(dcd_n),
		.port_power_request_i(req), .oc_sense_n_i(sense_n),
		.oc_gang_gpio_n_i(gpio_n), .port_power_control_o(ctl),
		.port_power_control_oe_o(ctl_oe), .chg_mode_o(chg), .prof_2a_o(p2a),
		.short_emul_o(shrt), .legacy_drive_o(leg), .oc2_o(oc2), .oc3_o(oc3),
		.port_off_o(off), .dpdm_swap_o(swp), .sm_sel_o(smsel),
		.compound_o(cmp), .power_switch_control_o(psw), .power_good_o(pg),
		.vid_o(vid), .pid2_o(pid2), .pid3_o(pid3), .mfg_len_o(mlen),
		.prod_len_o(plen), .ser_len_o(slen), .cfg_err_o(cerr));
	ppc_switch_model u_ppc_switch_model (
		.mclk_i(mclk_i), .ctl_i(ctl), .oe_i(ctl_oe),
		.comb_i({3'b111, pc.combined}), .fault_i(flt), .sense_n_o(sense_n));
	// Bus-free access: wait cycles, compare, and close the run
	task automatic cyc(input int n);
		repeat (n) @(negedge mclk_i);
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e)
		begin
			err_count++;
			$display("Error %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic oc_try(input int n, output logic s2, output logic s3);
		s2 = 1'b0;
		s3 = 1'b0;
		flt[0] = 1'b1;
		for (int k = 0; k < n + 8; k++)
		begin
			if (k == n)
				flt[0] = 1'b0;
			@(negedge mclk_i);
			s2 |= oc2[0];
			s3 |= oc3[0];
		end
	endtask
	task automatic tally_and_finish;
		$display("Checks %0d, mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Hang guard
	always @(posedge mclk_i)
	begin
		cyc_count++;
		if (cyc_count == 20000)
		begin
			err_count++;
			tally_and_finish();
		end
	end
	// Test sequence
	initial
	begin
		logic s2, s3;
		int   a, b;
		gc.vid = 16'hA5C3;
		gc.pid2 = 16'h0102;
		gc.pid3 = 16'h0304;
		gc.mfg_len = 6'd45;
		gc.prod_len = 6'd31;
		gc.ser_len = 6'd12;
		pc.disable_p = 7'h7A;
		pc.nonrem = 7'h01;
		pc.swap = 8'hA5;
		pc.sm_sel = 4'hF;
		st.disable_p = 4'h5;
		cyc(3);
		for (int i = 0; i < NPORT; i++)
			chk(chg[i], PPC_CHG_OFF);
		chk(vid, 16'h0000);
		cyc(1);
		resetn_i = 1'b1;
		cyc(3);
		chk({vid, pid2}, {16'hA5C3, 16'h0102});
		chk(pid3, 16'h0304);
		chk({mlen, plen, slen}, {6'd30, 6'd30, 6'd12});
		chk(swp, 8'hA5);
		chk(off, 7'h75);
		chk(cmp, 1'b0);
		pc.nonrem = 7'h10;
		cyc(2);
		chk(cmp, 1'b1);
		gc.strap_dis = 1'b1;
		cyc(2);
		chk(off, 7'h7A);
		$display("Test straps and ids done");
		pc.disable_p = '0;
		pc.chg_en = 7'h07;
		pc.legacy = 7'h02;
		pc.prof_2a = 7'h07;
		cyc(2);
		chk({chg[2], chg[1], chg[0]}, {PPC_CHG_DCP, PPC_CHG_LEG, PPC_CHG_DCP});
		chk({shrt, leg, p2a}, {7'h05, 7'h02, 7'h05});
		chk(smsel, 4'h7);
		dcd_n = 1'b0;
		cyc(4);
		chk({chg[2], chg[1], chg[0]}, {3{PPC_CHG_OFF}});
		chk({shrt, leg}, 14'h0);
		dcd_n = 1'b1;
		cyc(4);
		chk({chg[1], shrt}, {PPC_CHG_LEG, 7'h05});
		gc.pon_time = 8'h01;
		req[0] = 1'b1;
		cyc(PCYC + 6);
		chk({chg[0], shrt, p2a}, {PPC_CHG_CDP, 7'h04, 7'h05});
		$display("Test charging modes done");
		pc.chg_en = '0;
		req[0] = 1'b0;
		gc.pon_time = 8'h03;
		cyc(3);
		req[0] = 1'b1;
		cyc(3 * PCYC + 1);
		chk(pg[0], 1'b0);
		cyc(2);
		chk(pg[0], 1'b1);
		gc.no_pwr_ctl = 1'b1;
		req[1] = 1'b1;
		cyc(3);
		chk({pg[1], psw}, 2'h3);
		gc.no_pwr_ctl = 1'b0;
		$display("Test power good done");
		for (int s = 0; s < 4; s++)
		begin
			gc.oc2_sel = 2'(s);
			gc.oc3_sel = 2'(s);
			cyc(2);
			a = (n2[s] + CLK_NS - 1) / CLK_NS;
			b = (n3[s] + CLK_NS - 1) / CLK_NS;
			oc_try(a - 1, s2, s3);
			chk(s2, 1'b0);
			oc_try(b - 1, s2, s3);
			chk({s2, s3}, 2'h2);
			oc_try(b + 4, s2, s3);
			chk(s3, 1'b1);
		end
		$display("Test overcurrent filters done");
		req = 7'h7F;
		gc.oc_mode = PPC_OC_ALL;
		cyc(3);
		flt[2] = 1'b1;
		cyc(30);
		chk(oc2, 7'h7F);
		flt[2] = 1'b0;
		gc.pwr_gang = 1'b1;
		req = 7'h01;
		cyc(30);
		chk({ctl_oe, ctl[3:0]}, {7'h0F, 4'hF});
		pc.chg_en = 7'h01;
		cyc(2);
		chk(cerr, 1'b1);
		pc.chg_en = '0;
		gc.pwr_gang = 1'b0;
		gc.oc_mode = PPC_OC_SPLIT;
		gc.split_gang2 = 1'b1;
		pc.split_sel = 7'h03;
		gpio_n = 1'b0;
		cyc(40);
		chk(oc2, 7'h03);
		gpio_n = 1'b1;
		$display("Test ganging done");
		resetn_i = 1'b0;
		cyc(2);
		chk({vid, pg}, 23'h0);
		resetn_i = 1'b1;
		cyc(3);
		chk(vid, 16'hA5C3);
		$display("Test second reset done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
